// ### design/aea_defines.svh
// Constant names for the apparent energy accumulator block
`ifndef AEA_DEFINES_SVH
`define AEA_DEFINES_SVH

// Register offsets on the plain register port
`define AEA_OFF_GAIN_A 8'h00
`define AEA_OFF_GAIN_B 8'h01
`define AEA_OFF_GAIN_C 8'h02
`define AEA_OFF_ENERGY_A 8'h03
`define AEA_OFF_ENERGY_B 8'h04
`define AEA_OFF_ENERGY_C 8'h05
`define AEA_OFF_DIVIDER 8'h06
`define AEA_OFF_MASK 8'h07
`define AEA_OFF_LINE_CYCLE 8'h08
`define AEA_OFF_COMP_MODE 8'h09
`define AEA_OFF_WAVE_MODE 8'h0a
`define AEA_OFF_PULSE_NUM 8'h0b
`define AEA_OFF_PULSE_DEN 8'h0c
`define AEA_OFF_ZC_COUNT 8'h0d
`define AEA_OFF_VRMS_GAIN 8'h0e

// Field positions
`define AEA_BIT_HALF_FULL_MASK 2
`define AEA_BIT_LC_ACTIVE 0
`define AEA_BIT_LC_REACTIVE 1
`define AEA_BIT_LC_APPARENT 2
`define AEA_BIT_READ_CLEAR 6
`define AEA_BIT_PULSE_SOURCE 7
`define AEA_CONNECTION_SELECT_LSB 0
`define AEA_CONNECTION_SELECT_MSB 1
`define AEA_PHASE_TERM_SELECT_LSB 2
`define AEA_PHASE_TERM_SELECT_MSB 4
`define AEA_CONNECTION_SELECT_HALF_SUM 2'h1

// Reset values
`define AEA_RST_GAIN 12'h000
`define AEA_RST_DIVIDER 8'h00
`define AEA_RST_MASK 16'h0000
`define AEA_RST_LINE_CYCLE 8'h00
`define AEA_RST_COMP_MODE 8'h1c
`define AEA_RST_WAVE_MODE 8'h00
`define AEA_RST_PULSE_RATIO 12'h000
`define AEA_RST_ZC_COUNT 16'hffff

// Datapath scaling
`define AEA_GAIN_SHIFT 12
`define AEA_PWR_MSB 48
`define AEA_PWR_LSB 29
`define AEA_ENERGY_MSB 40
`define AEA_ENERGY_LSB 25
`define AEA_DFC_THRESHOLD 32'h80000000

// Timing counts, in cycles of the 200 MHz clock
`define AEA_TICK_LAST 2'h3
`define AEA_PULSE_WIDTH 7'h40

`endif

// ### design/aea_pkg.sv
// Types shared by the apparent energy accumulator block
package aea_pkg;

   // One register port request
   typedef struct packed {
      logic [7:0] addr;   // Register offset
      logic [15:0] wdata; // Write data
      logic wr;           // Write strobe
      logic rd;           // Read strobe
   } aea_reg_req_t;

   // Per-phase rms results from the rms engines
   typedef struct packed {
      logic [23:0] phase_a_voltage_rms;
      logic [23:0] phase_b_voltage_rms;
      logic [23:0] phase_c_voltage_rms;
      logic [23:0] phase_a_current_rms;
      logic [23:0] phase_b_current_rms;
      logic [23:0] phase_c_current_rms;
   } aea_rms_t;

endpackage

// ### design/aea_top.sv
// Apparent power, energy accumulation and shared pulse output of a 3-phase meter
`timescale 1ns/1ps
`include "aea_defines.svh"

module aea_top
   import aea_pkg::*;
(
   input wire logic clock,                         // 200 MHz clock
   input wire logic srst,                          // Synchronous reset, active high
   input wire aea_reg_req_t reg_req,               // Register port request
   output logic [15:0] reg_rdata,                  // Read data, cycle after read strobe
   input wire aea_rms_t rms_in,                    // Offset-corrected rms values
   input wire logic zero_cross,                    // Zero-crossing pulse
   input wire logic [23:0] reactive_total,         // Total reactive power magnitude
   output logic reactive_apparent_pulse_out,       // Shared frequency output
   output logic half_full_event,                   // Half-full event pulse
   output logic line_cycle_end,                    // Line-cycle window end pulse
   output logic line_cycle_active_enable,          // Window request for active path
   output logic line_cycle_reactive_enable         // Window request for reactive path
);

   // Software registers
   logic [11:0] gain_reg [3];                 // Per-phase apparent gain
   logic [7:0] apparent_energy_divider_reg;   // Energy divider
   logic [15:0] mask_reg;                     // Event mask
   logic [7:0] line_cycle_mode_reg;           // Line-cycle mode
   logic [7:0] computation_mode_reg;          // Connection and term select
   logic [7:0] waveform_mode_reg;             // Pulse source select
   logic [11:0] pulse_divider_numerator_reg;  // Output ratio numerator
   logic [11:0] pulse_divider_denominator_reg; // Output ratio denominator
   logic [15:0] zero_crossing_count_reg;      // Crossings per window
   logic [11:0] voltage_rms_gain_reg;         // Voltage rms gain

   // Field decode
   wire [1:0] connection_select = computation_mode_reg[`AEA_CONNECTION_SELECT_MSB:`AEA_CONNECTION_SELECT_LSB];
   wire [2:0] phase_term_select = computation_mode_reg[`AEA_PHASE_TERM_SELECT_MSB:`AEA_PHASE_TERM_SELECT_LSB];
   wire pulse_source_select = waveform_mode_reg[`AEA_BIT_PULSE_SOURCE];
   wire apparent_half_full_mask = mask_reg[`AEA_BIT_HALF_FULL_MASK];
   wire read_clear_enable = line_cycle_mode_reg[`AEA_BIT_READ_CLEAR];
   wire line_cycle_apparent_enable = line_cycle_mode_reg[`AEA_BIT_LC_APPARENT];
   // Any path in line-cycle mode keeps the shared window counting
   wire any_line_cycle = |line_cycle_mode_reg[`AEA_BIT_LC_APPARENT:`AEA_BIT_LC_ACTIVE];

   // Write decode
   wire wr_gain_a = reg_req.wr && (reg_req.addr == `AEA_OFF_GAIN_A);
   wire wr_gain_b = reg_req.wr && (reg_req.addr == `AEA_OFF_GAIN_B);
   wire wr_gain_c = reg_req.wr && (reg_req.addr == `AEA_OFF_GAIN_C);
   wire wr_divider = reg_req.wr && (reg_req.addr == `AEA_OFF_DIVIDER);
   wire wr_mask = reg_req.wr && (reg_req.addr == `AEA_OFF_MASK);
   wire wr_line_cycle = reg_req.wr && (reg_req.addr == `AEA_OFF_LINE_CYCLE);
   wire wr_comp_mode = reg_req.wr && (reg_req.addr == `AEA_OFF_COMP_MODE);
   wire wr_wave_mode = reg_req.wr && (reg_req.addr == `AEA_OFF_WAVE_MODE);
   wire wr_pulse_num = reg_req.wr && (reg_req.addr == `AEA_OFF_PULSE_NUM);
   wire wr_pulse_den = reg_req.wr && (reg_req.addr == `AEA_OFF_PULSE_DEN);
   wire wr_zc_count = reg_req.wr && (reg_req.addr == `AEA_OFF_ZC_COUNT);
   wire wr_vrms_gain = reg_req.wr && (reg_req.addr == `AEA_OFF_VRMS_GAIN);
   // Gain strobes gathered for the per-phase loop
   wire [2:0] wr_gain = {wr_gain_c, wr_gain_b, wr_gain_a};

   // Read decode of the energy registers, per phase
   wire [2:0] rd_energy = {reg_req.rd && (reg_req.addr == `AEA_OFF_ENERGY_C),
                           reg_req.rd && (reg_req.addr == `AEA_OFF_ENERGY_B),
                           reg_req.rd && (reg_req.addr == `AEA_OFF_ENERGY_A)};
   // Clear after read, only when software asked for it
   wire [2:0] clear_energy = rd_energy & {3{read_clear_enable}};

   // Gain registers, one per phase
   generate
      for (genvar g = 0; g < 3; g++) begin : g_gain
         // Software-written gain
         always_ff @(posedge clock) begin
            if (srst) begin
               gain_reg[g] <= `AEA_RST_GAIN;
            end else if (wr_gain[g]) begin
               gain_reg[g] <= reg_req.wdata[11:0];
            end
         end
      end
   endgenerate

   // Remaining control registers
   always_ff @(posedge clock) begin
      if (srst) begin
         apparent_energy_divider_reg <= `AEA_RST_DIVIDER;
         mask_reg <= `AEA_RST_MASK;
         line_cycle_mode_reg <= `AEA_RST_LINE_CYCLE;
         computation_mode_reg <= `AEA_RST_COMP_MODE;
         waveform_mode_reg <= `AEA_RST_WAVE_MODE;
         pulse_divider_numerator_reg <= `AEA_RST_PULSE_RATIO;
         pulse_divider_denominator_reg <= `AEA_RST_PULSE_RATIO;
         zero_crossing_count_reg <= `AEA_RST_ZC_COUNT;
         voltage_rms_gain_reg <= `AEA_RST_GAIN;
      end else begin
         if (wr_divider) apparent_energy_divider_reg <= reg_req.wdata[7:0];
         if (wr_mask) mask_reg <= reg_req.wdata;
         if (wr_line_cycle) line_cycle_mode_reg <= reg_req.wdata[7:0];
         if (wr_comp_mode) computation_mode_reg <= reg_req.wdata[7:0];
         if (wr_wave_mode) waveform_mode_reg <= reg_req.wdata[7:0];
         if (wr_pulse_num) pulse_divider_numerator_reg <= reg_req.wdata[11:0];
         if (wr_pulse_den) pulse_divider_denominator_reg <= reg_req.wdata[11:0];
         if (wr_zc_count) zero_crossing_count_reg <= reg_req.wdata;
         if (wr_vrms_gain) voltage_rms_gain_reg <= reg_req.wdata[11:0];
      end
   end

   // Sample tick: one cycle in four
   logic [1:0] tick_cnt_reg; // Free-running phase counter
   wire tick = (tick_cnt_reg == `AEA_TICK_LAST);
   always_ff @(posedge clock) begin
      if (srst) begin
         tick_cnt_reg <= 2'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 2'h1;
      end
   end

   // Line-cycle window: shared by active, reactive and apparent paths
   logic [15:0] zc_left_reg;   // Crossings still to come in the window
   logic lc_apparent_d_reg;    // Previous apparent line-cycle enable
   wire lc_last = (zc_left_reg <= 16'h0001);
   wire lc_end_now = any_line_cycle && zero_cross && lc_last;
   wire lc_start = line_cycle_apparent_enable && !lc_apparent_d_reg;
   always_ff @(posedge clock) begin
      if (srst) begin
         zc_left_reg <= `AEA_RST_ZC_COUNT;
         lc_apparent_d_reg <= 1'b0;
         line_cycle_end <= 1'b0;
      end else begin
         lc_apparent_d_reg <= line_cycle_apparent_enable;
         line_cycle_end <= lc_end_now;
         // Reload on window end or while idle, so each window counts in full
         if (!any_line_cycle || lc_end_now || lc_start) begin
            zc_left_reg <= zero_crossing_count_reg;
         end else if (zero_cross) begin
            zc_left_reg <= zc_left_reg - 16'h0001;
         end
      end
   end
   // Window requests for the active and reactive paths
   assign line_cycle_active_enable = line_cycle_mode_reg[`AEA_BIT_LC_ACTIVE];
   assign line_cycle_reactive_enable = line_cycle_mode_reg[`AEA_BIT_LC_REACTIVE];

   // Voltage before rms gain; the half-sum only ever feeds phase B
   wire [24:0] volt_half_sum = ({1'b0, rms_in.phase_a_voltage_rms} +
                                {1'b0, rms_in.phase_c_voltage_rms}) >> 1;
   wire [23:0] volt_b_sel = (connection_select == `AEA_CONNECTION_SELECT_HALF_SUM) ?
                            volt_half_sum[23:0] : rms_in.phase_b_voltage_rms;
   wire [23:0] volt_in [3];
   wire [23:0] curr_in [3];
   assign volt_in[0] = rms_in.phase_a_voltage_rms;
   assign volt_in[1] = volt_b_sel;
   assign volt_in[2] = rms_in.phase_c_voltage_rms;
   assign curr_in[0] = rms_in.phase_a_current_rms;
   assign curr_in[1] = rms_in.phase_b_current_rms;
   assign curr_in[2] = rms_in.phase_c_current_rms;

   // Per-phase state
   logic [20:0] power_reg [3];     // Gained apparent power, one per tick
   logic [40:0] acc_reg [3];       // Internal energy accumulator
   logic [15:0] hold_reg [3];      // Line-cycle result
   logic [15:0] energy_view [3];   // Readable energy register
   logic [2:0] msb_prev_reg;       // Bit 15 seen at the last step
   logic [2:0] msb_change;         // Bit 15 changed this step

   generate
      for (genvar p = 0; p < 3; p++) begin : g_phase
         // Rms voltage gain, the same law as the power gain
         wire signed [37:0] vg_prod = $signed({1'b0, volt_in[p]}) *
                                      $signed(voltage_rms_gain_reg);
         wire signed [37:0] vg_sum = $signed({2'b00, volt_in[p], 12'h000}) + vg_prod;
         wire [24:0] volt_gained = vg_sum[`AEA_GAIN_SHIFT+24:`AEA_GAIN_SHIFT];
         // Plain product; offsets were removed upstream in the rms engines
         wire [48:0] va_prod = volt_gained * {1'b0, curr_in[p]};
         wire [19:0] va_raw = va_prod[`AEA_PWR_MSB:`AEA_PWR_LSB];
         // Phase gain: power * (1 + gain / 4096), gain signed
         wire signed [33:0] pg_prod = $signed({1'b0, va_raw}) * $signed(gain_reg[p]);
         wire signed [33:0] pg_sum = $signed({2'b00, va_raw, 12'h000}) + pg_prod;
         // Gain 0x800 gives half, 0x7ff about one and a half; never negative
         wire [20:0] va_gained = pg_sum[`AEA_GAIN_SHIFT+20:`AEA_GAIN_SHIFT];
         // Divider 0 or 1 passes the power through unchanged
         wire no_div = (apparent_energy_divider_reg <= 8'h01);
         wire [20:0] va_div = no_div ? power_reg[p] :
                              power_reg[p] / {13'h0000, apparent_energy_divider_reg};
         // Rolls over past 41 bits and keeps counting up
         wire [40:0] acc_sum = acc_reg[p] + {20'h00000, va_div};
         wire [40:0] acc_fresh = tick ? {20'h00000, va_div} : 41'h0;
         // Total up to and including this cycle; only a tick adds
         wire [40:0] acc_step = tick ? acc_sum : acc_reg[p];
         wire lc_mode = line_cycle_apparent_enable;

         // Register the gained power once per tick
         always_ff @(posedge clock) begin
            if (srst) begin
               power_reg[p] <= 21'h000000;
            end else if (tick) begin
               power_reg[p] <= va_gained;
            end
         end

         // Accumulator: wraps on overflow, restarts per window, or on clear outside line-cycle mode
         always_ff @(posedge clock) begin
            if (srst) begin
               acc_reg[p] <= 41'h0;
            end else if (lc_mode && lc_end_now) begin
               // The closing tick went into the result, so the next window starts empty
               acc_reg[p] <= 41'h0;
            end else if (lc_mode && lc_start) begin
               acc_reg[p] <= acc_fresh;
            end else if (!lc_mode && clear_energy[p]) begin
               acc_reg[p] <= acc_fresh;
            end else if (tick) begin
               acc_reg[p] <= acc_sum;
            end
         end

         // Window result, written at the window end and zeroed by a read clear
         always_ff @(posedge clock) begin
            if (srst) begin
               hold_reg[p] <= 16'h0000;
            end else if (lc_mode && lc_end_now) begin
               hold_reg[p] <= acc_step[`AEA_ENERGY_MSB:`AEA_ENERGY_LSB];
            end else if (lc_mode && clear_energy[p]) begin
               hold_reg[p] <= 16'h0000;
            end
         end

         // Live upper bits, or the window result in line-cycle mode
         assign energy_view[p] = lc_mode ? hold_reg[p] :
                                 acc_reg[p][`AEA_ENERGY_MSB:`AEA_ENERGY_LSB];
         assign msb_change[p] = energy_view[p][15] ^ msb_prev_reg[p];

         // Track bit 15; a read clear resets the reference to avoid a false event
         always_ff @(posedge clock) begin
            if (srst) begin
               msb_prev_reg[p] <= 1'b0;
            end else if (clear_energy[p]) begin
               msb_prev_reg[p] <= 1'b0;
            end else if (tick) begin
               msb_prev_reg[p] <= energy_view[p][15];
            end
         end
      end
   endgenerate

   // Half-full event, gated by its mask bit
   always_ff @(posedge clock) begin
      if (srst) begin
         half_full_event <= 1'b0;
      end else begin
         half_full_event <= tick && apparent_half_full_mask && (|msb_change);
      end
   end

   // Total apparent power over the selected phases
   wire [22:0] total_apparent = (phase_term_select[0] ? {2'b00, power_reg[0]} : 23'h0) +
                                (phase_term_select[1] ? {2'b00, power_reg[1]} : 23'h0) +
                                (phase_term_select[2] ? {2'b00, power_reg[2]} : 23'h0);
   // Pulse source: reactive by default, apparent when selected
   wire [23:0] dfc_in = pulse_source_select ? {1'b0, total_apparent} : reactive_total;

   // Digital-to-frequency converter: one pulse per threshold of energy
   logic [31:0] dfc_acc_reg;  // Converter energy store
   wire [32:0] dfc_sum = {1'b0, dfc_acc_reg} + {9'h000, dfc_in};
   // Fires at most once per tick; the store keeps the remainder
   wire dfc_fire = tick && (dfc_sum >= {1'b0, `AEA_DFC_THRESHOLD});
   always_ff @(posedge clock) begin
      if (srst) begin
         dfc_acc_reg <= 32'h0;
      end else if (dfc_fire) begin
         dfc_acc_reg <= 32'(dfc_sum - {1'b0, `AEA_DFC_THRESHOLD});
      end else if (tick) begin
         dfc_acc_reg <= dfc_sum[31:0];
      end
   end

   // Ratio divider: num added per converter pulse, output each time den is reached
   wire [12:0] ratio_num = (pulse_divider_numerator_reg == 12'h000) ? 13'h0001 :
                           {1'b0, pulse_divider_numerator_reg};
   wire [12:0] ratio_den = (pulse_divider_denominator_reg == 12'h000) ? 13'h0001 :
                           {1'b0, pulse_divider_denominator_reg};
   logic [12:0] ratio_acc_reg;  // Fractional pulse credit
   wire [13:0] ratio_sum = {1'b0, ratio_acc_reg} + {1'b0, ratio_num};
   wire ratio_fire = dfc_fire && (ratio_sum >= {1'b0, ratio_den});
   always_ff @(posedge clock) begin
      if (srst) begin
         ratio_acc_reg <= 13'h0000;
      end else if (ratio_fire) begin
         ratio_acc_reg <= 13'(ratio_sum - {1'b0, ratio_den});
      end else if (dfc_fire) begin
         ratio_acc_reg <= ratio_sum[12:0];
      end
   end

   // Output pulse stretcher; a fresh pulse restarts the width
   logic [6:0] pulse_cnt_reg;  // Cycles left high
   always_ff @(posedge clock) begin
      if (srst) begin
         pulse_cnt_reg <= 7'h00;
         reactive_apparent_pulse_out <= 1'b0;
      end else if (ratio_fire) begin
         pulse_cnt_reg <= `AEA_PULSE_WIDTH - 7'h01;
         reactive_apparent_pulse_out <= 1'b1;
      end else if (pulse_cnt_reg != 7'h00) begin
         pulse_cnt_reg <= pulse_cnt_reg - 7'h01;
      end else begin
         reactive_apparent_pulse_out <= 1'b0;
      end
   end

   // Read data selection; unmapped offsets read zero
   logic [15:0] rdata_next;
   always_comb begin
      case (reg_req.addr)
         `AEA_OFF_GAIN_A: rdata_next = {4'h0, gain_reg[0]};
         `AEA_OFF_GAIN_B: rdata_next = {4'h0, gain_reg[1]};
         `AEA_OFF_GAIN_C: rdata_next = {4'h0, gain_reg[2]};
         `AEA_OFF_ENERGY_A: rdata_next = energy_view[0];
         `AEA_OFF_ENERGY_B: rdata_next = energy_view[1];
         `AEA_OFF_ENERGY_C: rdata_next = energy_view[2];
         `AEA_OFF_DIVIDER: rdata_next = {8'h00, apparent_energy_divider_reg};
         `AEA_OFF_MASK: rdata_next = mask_reg;
         `AEA_OFF_LINE_CYCLE: rdata_next = {8'h00, line_cycle_mode_reg};
         `AEA_OFF_COMP_MODE: rdata_next = {8'h00, computation_mode_reg};
         `AEA_OFF_WAVE_MODE: rdata_next = {8'h00, waveform_mode_reg};
         `AEA_OFF_PULSE_NUM: rdata_next = {4'h0, pulse_divider_numerator_reg};
         `AEA_OFF_PULSE_DEN: rdata_next = {4'h0, pulse_divider_denominator_reg};
         `AEA_OFF_ZC_COUNT: rdata_next = zero_crossing_count_reg;
         `AEA_OFF_VRMS_GAIN: rdata_next = {4'h0, voltage_rms_gain_reg};
         default: rdata_next = 16'h0000;
      endcase
   end

   // Read data register; old value captured before any clear lands
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_req.rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// ### sim/aea_front_model.sv
// Front-end stand-in: rms results and zero-crossing pulses
`timescale 1ns/1ps
module aea_front_model
   import aea_pkg::*;
(
   input wire logic clock, // 200 MHz clock
   input wire logic srst, // Synchronous reset
   input wire logic zc_run, // Crossings enabled
   output aea_rms_t rms_in, // Rms results, levels
   output logic zero_cross // One-cycle crossing pulse
);
   logic [10:0] gap_reg; // Cycles since last crossing
   initial rms_in = '0;
   // New rms levels land just after an edge
   task automatic set_rms(input aea_rms_t v);
      @(posedge clock);
      rms_in <= v;
   endtask
   // Crossings every 2048 cycles, a multiple of the tick, so windows hold whole ticks
   always_ff @(posedge clock) begin
      if (srst || !zc_run) begin
         gap_reg <= 11'h000;
         zero_cross <= 1'b0;
      end else begin
         gap_reg <= gap_reg + 11'h001;
         zero_cross <= (gap_reg == 11'h7ff);
      end
   end
endmodule

// ### sim/aea_monitor.sv
// Port checker for the apparent energy block
`timescale 1ns/1ps
module aea_monitor
   import aea_pkg::*;
(
   input wire logic clock, // Clock
   input wire logic srst, // Reset
   input wire aea_reg_req_t reg_req, // Register request
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic zero_cross, // Crossing pulse
   input wire logic reactive_apparent_pulse_out, // Pulse output
   input wire logic half_full_event, // Half-full pulse
   input wire logic line_cycle_end, // Window end pulse
   input wire logic line_cycle_active_enable, // Active window request
   input wire logic line_cycle_reactive_enable // Reactive window request
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   logic [1:0] tick_reg; // Mirror of the tick phase
   logic mask_reg; // Mirror of the half-full mask
   logic [7:0] high_reg; // Cycles the pulse has stood high
   // Mirrors realign on every reset, as the design does
   always_ff @(posedge clock) begin
      if (srst) begin
         tick_reg <= 2'h0;
         mask_reg <= 1'b0;
      end else begin
         tick_reg <= tick_reg + 2'h1;
         if (reg_req.wr && reg_req.addr == 8'h07) mask_reg <= reg_req.wdata[2];
      end
   end
   // Length of the current high stretch
   always_ff @(posedge clock) begin
      high_reg <= (srst || !reactive_apparent_pulse_out) ? 8'h00 : high_reg + 8'h01;
   end
   sequence s_lc_write;
      reg_req.wr && reg_req.addr == 8'h08;
   endsequence
   sequence s_pulse_end;
      reactive_apparent_pulse_out ##1 !reactive_apparent_pulse_out;
   endsequence
   a_rdata_idle_zero: assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_pulse_width_64: assert property (s_pulse_end |-> high_reg == 8'h40)
      else $error("pulse width not 64");
   a_pulse_not_long: assert property (reactive_apparent_pulse_out |-> high_reg < 8'h40)
      else $error("pulse too long");
   a_lc_enable_track: assert property (s_lc_write |=> line_cycle_active_enable ==
      $past(reg_req.wdata[0]) && line_cycle_reactive_enable == $past(reg_req.wdata[1]))
      else $error("window enables wrong");
   a_end_after_zc: assert property (line_cycle_end |-> $past(zero_cross))
      else $error("window end without crossing");
   a_end_single: assert property (line_cycle_end |=> !line_cycle_end)
      else $error("window end too long");
   a_hf_on_tick: assert property (half_full_event |-> tick_reg == 2'h0)
      else $error("half-full off tick");
   a_hf_masked: assert property (half_full_event |-> mask_reg || $past(mask_reg))
      else $error("half-full while masked");
   a_hf_single: assert property (half_full_event |=> !half_full_event)
      else $error("half-full too long");
endmodule
bind aea_top aea_monitor u_mon (.clock(clock), .srst(srst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .zero_cross(zero_cross),
   .reactive_apparent_pulse_out(reactive_apparent_pulse_out),
   .half_full_event(half_full_event), .line_cycle_end(line_cycle_end),
   .line_cycle_active_enable(line_cycle_active_enable),
   .line_cycle_reactive_enable(line_cycle_reactive_enable));

// ### sim/testbench.sv
// Self-checking bench for the apparent energy block
`timescale 1ns/1ps
module testbench
   import aea_pkg::*;
;
   logic clock = 1'b0; // 200 MHz clock
   logic srst = 1'b1; // Synchronous reset
   aea_reg_req_t req = '0; // Register request
   logic [23:0] reactive_total = 24'h000000; // Reactive level
   logic zc_run = 1'b0; // Crossing source on
   aea_rms_t rms; // Rms levels
   logic zc; // Crossing pulse
   logic [15:0] rdata; // Read data
   logic pulse_out; // Shared pulse
   logic lc_end; // Window end
   logic hf; // Half-full pulse
   logic hf_seen = 1'b0; // Any half-full pulse seen
   int fails = 0; // Mismatches
   int checked = 0; // Comparisons
   logic [15:0] seed = 16'h0042; // Random state
   longint vlt[3] = '{64'h800000, 64'h400000, 64'h800000}; // Phase voltages
   longint cur[3] = '{64'hc00000, 64'h800000, 64'h400000}; // Phase currents
   aea_front_model fm (.clock(clock), .srst(srst), .zc_run(zc_run), .rms_in(rms),
      .zero_cross(zc));
   aea_top dut (.clock(clock), .srst(srst), .reg_req(req), .reg_rdata(rdata), .rms_in(rms),
      .zero_cross(zc), .reactive_total(reactive_total), .reactive_apparent_pulse_out(pulse_out),
      .half_full_event(hf), .line_cycle_end(lc_end), .line_cycle_active_enable(),
      .line_cycle_reactive_enable());
   initial begin
      forever #2.5 clock = ~clock;
   end
   // Energy bit 15 never moves within this run, so any pulse is false
   always @(posedge clock) if (!srst && hf !== 1'b0) hf_seen <= 1'b1;
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Gained power per tick; each step rounds down, as the design's bit slices do
   function automatic longint pwr(longint v, longint i, longint vg, longint g);
      return ((((v * (4096 + vg)) / 4096) * i) >> 29) * (4096 + g) / 4096;
   endfunction
   task automatic print_verdict();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Bounded wait for a window end
   task automatic wait_end();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (lc_end !== 1'b1 && n < 5000);
      if (n >= 5000) chk_rng(0, 1, 1);
   endtask
   // Second window spans two crossings' worth: exactly 1024 ticks
   task automatic lc_case(input logic [1:0] c);
      logic [11:0] g[3];
      longint dv;
      seed = lfsr(seed);
      dv = (seed[2:0] > 3'h1) ? longint'(seed[2:0]) : 64'sd1;
      wr(8'h06, {13'h0000, seed[2:0]});
      wr(8'h09, {11'h000, 3'h7, c});
      for (int p = 0; p < 3; p++) begin
         seed = lfsr(seed);
         g[p] = seed[11:0];
         wr(8'(p), {4'h0, g[p]});
         rdc(8'(p), {4'h0, g[p]});
      end
      wr(8'h08, 16'h0004);
      @(posedge clock);
      zc_run <= 1'b1;
      wait_end();
      wait_end();
      zc_run <= 1'b0;
      for (int p = 0; p < 3; p++)
         rdc(8'(p + 3), 16'((1024 * (pwr((p == 1 && c == 2'h1) ? vlt[0] : vlt[p], cur[p], 128,
            longint'($signed(g[p]))) / dv)) >> 25));
      wr(8'h08, 16'h0000);
   endtask
   task automatic count_pulses(input int cyc, output int n);
      logic prev;
      n = 0;
      prev = pulse_out;
      repeat (cyc) begin
         @(posedge clock);
         #1 if (pulse_out === 1'b1 && prev !== 1'b1) n++;
         prev = pulse_out;
      end
   endtask
   initial begin
      int n;
      int e;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      for (int a = 0; a < 16; a++)
         rdc(8'(a), (a == 9) ? 16'h001c : (a == 13) ? 16'hffff : 16'h0000);
      wr(8'h07, 16'h0004);
      wr(8'h0d, 16'h0002);
      wr(8'h0e, 16'h0080);
      fm.set_rms({24'h800000, 24'h400000, 24'h800000, 24'hc00000, 24'h800000, 24'h400000});
      for (int c = 0; c < 4; c++) lc_case(2'(c));
      wr(8'h02, 16'h07ff);
      wr(8'h06, 16'h0000);
      wr(8'h08, 16'h0040);
      // Clear, then 4096 cycles hold exactly 1024 ticks of phase C
      rdc(8'h05, 16'h0000);
      repeat (4094) @(posedge clock);
      rdc(8'h05, 16'((1024 * pwr(vlt[2], cur[2], 128, 2047)) >> 25));
      rdc(8'h05, 16'h0000);
      wr(8'h05, 16'hffff);
      rdc(8'h05, 16'h0000);
      wr(8'h08, 16'h0000);
      reactive_total <= 24'hffffff;
      count_pulses(8192, n);
      chk_rng(n, 14, 17);
      wr(8'h0b, 16'h0001);
      wr(8'h0c, 16'h0004);
      count_pulses(8192, n);
      chk_rng(n, 3, 5);
      wr(8'h0b, 16'h0000);
      wr(8'h0c, 16'h0000);
      wr(8'h0a, 16'h0080);
      wr(8'h09, 16'h0000);
      // A pulse launched by the last write is already high when counting starts
      repeat (2) @(posedge clock);
      count_pulses(4096, n);
      chk_rng(n, 0, 0);
      wr(8'h0e, 16'h0000);
      for (int p = 0; p < 3; p++) wr(8'(p), 16'h07ff);
      wr(8'h09, 16'h001c);
      fm.set_rms('1);
      count_pulses(16384, n);
      e = int'((4096 * 3 * pwr(64'hffffff, 64'hffffff, 0, 2047)) >> 31);
      chk_rng(n, e - 1, e + 1);
      chk({15'h0, hf_seen}, 16'h0000);
      print_verdict();
   end
   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      print_verdict();
   end
endmodule
